// [hdl/lds_pkg.sv]
package lds_pkg;
  // Byte addresses of the register window
  localparam logic [15:0] ADDR_CODE = 16'h2120;
  localparam logic [15:0] ADDR_SWITCH = 16'h2124;
  localparam logic [15:0] ADDR_CONFIG = 16'h2128;
  localparam int ADDR_W = 16;

  // Configuration field positions
  localparam int CFG_WRITE_EN = 0;
  localparam int CFG_POWER_DOWN = 1;
  localparam int CFG_REF_SEL = 2;
  localparam int CFG_BIAS_MUX = 3;
  localparam int CFG_ZERO_MUX = 4;
  localparam int CFG_PATTERN = 5;
  localparam int CFG_CODE_SRC = 6;
  localparam int CFG_W = 7;
  localparam logic [6:0] CFG_RESET = 7'h02;

  // Switch register field positions
  localparam int SW_OVERRIDE = 5;
  localparam int SW_W = 6;
  localparam logic [5:0] SW_RESET = 6'h0c;

  // Code register fields
  localparam int CODE_W = 18;
  localparam logic [17:0] CODE_RESET = 18'h00000;

  // Switch vectors, bit n drives switch n
  localparam int NSW = 5;
  localparam logic [4:0] PAT_NORMAL = 5'h0c;
  localparam logic [4:0] PAT_DIAG = 5'h11;
  localparam logic [4:0] PAT_OPEN = 5'h00;

  // Switch vector bit of each output switch
  localparam int SW_FAST_TIA = 0;
  localparam int SW_ZERO_FILTER = 1;
  localparam int SW_SLOW_TIA = 2;
  localparam int SW_BIAS_FILTER = 3;
  localparam int SW_BIAS_POT = 4;
endpackage

// [hdl/lds_apb_decode.sv]
`timescale 1ns/1ps
// Decodes APB accesses into one-cycle write strobes per register.
module lds_apb_decode (
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  output logic wr_code_o,
  output logic wr_switch_o,
  output logic wr_config_o,
  output logic hit_o
);
  logic wr_phase;

  always_comb begin
    wr_phase = psel_i && penable_i && pwrite_i;
    hit_o = (paddr_i == lds_pkg::ADDR_CODE) || (paddr_i == lds_pkg::ADDR_SWITCH) ||
            (paddr_i == lds_pkg::ADDR_CONFIG);
    wr_code_o = wr_phase && (paddr_i == lds_pkg::ADDR_CODE);
    wr_switch_o = wr_phase && (paddr_i == lds_pkg::ADDR_SWITCH);
    wr_config_o = wr_phase && (paddr_i == lds_pkg::ADDR_CONFIG);
  end
endmodule

// [hdl/lds_switch_route.sv]
`timescale 1ns/1ps
// Chooses the switch vector from pattern, override and power-down.
module lds_switch_route (
  input wire logic power_down_i,
  input wire logic pattern_sel_i,
  input wire logic override_i,
  input wire logic [4:0] manual_i,
  output logic [4:0] switches_o
);
  always_comb begin
    if (power_down_i) begin
      switches_o = lds_pkg::PAT_OPEN; // R8
    end else if (override_i) begin
      switches_o = manual_i; // R11
    end else if (pattern_sel_i) begin
      switches_o = lds_pkg::PAT_DIAG; // R3
    end else begin
      switches_o = lds_pkg::PAT_NORMAL; // R2
    end
  end
endmodule

// [hdl/lds_top.sv]
`timescale 1ns/1ps
// Operation
// R1 - Config bit 5 picks normal or diagnostic
// R2 - Normal pattern closes switches two, three
// R3 - Diagnostic pattern closes switches zero, four
// R4 - Config bit 4 routes zero node source
// R5 - Config bit 3 routes bias node source
// R6 - Software writes both mux bits equal
// R7 - Config bit 2 selects reference source
// R8 - Config bit 1 powers down, opens switches
// R9 - Config bit 0 gates code register writes
// R10 - Config bit 6 selects code source
// R11 - Switch bit 5 enables manual override
// R12 - Switch bit 4 drives switch four
// R13 - Switch bit 3 drives switch three
// R14 - Switch bit 2 drives switch two
// R15 - Switch bit 1 drives switch one
// R16 - Switch bit 0 drives switch zero
// R17 - Switch register at 0x2124, upper zero
// R18 - Registers 32-bit, reserved bits read zero
module lds_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [4:0] switch_close_o,
  output logic zero_node_source_select_o,
  output logic bias_node_source_select_o,
  output logic reference_source_select_o,
  output logic converter_power_down_o,
  output logic code_source_select_o,
  output logic [17:0] dac_code_o
);
  logic [6:0] cfg_q;
  logic [5:0] sw_q;
  logic [17:0] code_q;
  logic wr_code;
  logic wr_switch;
  logic wr_config;
  logic hit;
  logic [4:0] switch_d;
  logic setup_phase;

  lds_apb_decode u_decode (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .wr_code_o(wr_code),
    .wr_switch_o(wr_switch),
    .wr_config_o(wr_config),
    .hit_o(hit)
  );

  // Only implemented bits are stored, so reserved bits drop writes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= lds_pkg::CFG_RESET; // R8
    end else if (wr_config && pready_o) begin
      cfg_q <= pwdata_i[lds_pkg::CFG_W-1:0]; // R18
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_q <= lds_pkg::SW_RESET; // R13 R14
    end else if (wr_switch && pready_o) begin
      sw_q <= pwdata_i[lds_pkg::SW_W-1:0]; // R17
    end
  end

  // The code register is held cleared while writes are disabled
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      code_q <= lds_pkg::CODE_RESET;
    end else if (!cfg_q[lds_pkg::CFG_WRITE_EN]) begin
      code_q <= lds_pkg::CODE_RESET; // R9
    end else if (wr_code && pready_o) begin
      code_q <= pwdata_i[lds_pkg::CODE_W-1:0]; // R9
    end
  end

  lds_switch_route u_route (
    .power_down_i(cfg_q[lds_pkg::CFG_POWER_DOWN]),
    .pattern_sel_i(cfg_q[lds_pkg::CFG_PATTERN]),
    .override_i(sw_q[lds_pkg::SW_OVERRIDE]),
    .manual_i(sw_q[lds_pkg::NSW-1:0]),
    .switches_o(switch_d)
  );

  // Outputs are registered: they follow the registers one cycle later
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      switch_close_o <= lds_pkg::PAT_OPEN;
      zero_node_source_select_o <= 1'b0;
      bias_node_source_select_o <= 1'b0;
      reference_source_select_o <= 1'b0;
      converter_power_down_o <= 1'b1;
      code_source_select_o <= 1'b0;
      dac_code_o <= lds_pkg::CODE_RESET;
    end else begin
      switch_close_o <= switch_d; // R1 R12 R13 R14 R15 R16
      zero_node_source_select_o <= cfg_q[lds_pkg::CFG_ZERO_MUX]; // R4
      bias_node_source_select_o <= cfg_q[lds_pkg::CFG_BIAS_MUX]; // R5
      reference_source_select_o <= cfg_q[lds_pkg::CFG_REF_SEL]; // R7
      converter_power_down_o <= cfg_q[lds_pkg::CFG_POWER_DOWN]; // R8
      code_source_select_o <= cfg_q[lds_pkg::CFG_CODE_SRC]; // R10
      dac_code_o <= code_q;
    end
  end

  // No wait state: pready rises at the setup cycle's edge, high in the first access cycle
  always_comb begin
    setup_phase = psel_i && !penable_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (setup_phase) begin
      pready_o <= 1'b1;
      pslverr_o <= !hit;
      prdata_o <= 32'h00000000;
      if (!pwrite_i) begin
        if (paddr_i == lds_pkg::ADDR_CONFIG) begin
          prdata_o <= {25'h0000000, cfg_q}; // R18
        end else if (paddr_i == lds_pkg::ADDR_SWITCH) begin
          prdata_o <= {26'h0000000, sw_q}; // R17
        end else if (paddr_i == lds_pkg::ADDR_CODE) begin
          prdata_o <= {14'h0000, code_q};
        end
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Shorthands for the checks below
  logic chk_auto;
  logic chk_manual;
  logic chk_read;
  always_comb begin
    chk_auto = !cfg_q[lds_pkg::CFG_POWER_DOWN] && !sw_q[lds_pkg::SW_OVERRIDE];
    chk_manual = !cfg_q[lds_pkg::CFG_POWER_DOWN] && sw_q[lds_pkg::SW_OVERRIDE];
    chk_read = setup_phase && !pwrite_i;
  end

  property p_power_open;
    @(posedge clk_i) disable iff (reset_i)
      cfg_q[lds_pkg::CFG_POWER_DOWN] |=>
        switch_close_o == lds_pkg::PAT_OPEN;
  endproperty
  a_power_open: assert property (p_power_open) else $error("switches closed in power-down"); // R8

  property p_power_pin;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        converter_power_down_o == $past(cfg_q[lds_pkg::CFG_POWER_DOWN]);
  endproperty
  a_power_pin: assert property (p_power_pin) else $error("power-down pin wrong"); // R8

  property p_normal;
    @(posedge clk_i) disable iff (reset_i)
      (chk_auto && !cfg_q[lds_pkg::CFG_PATTERN]) |=>
        switch_close_o == lds_pkg::PAT_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("normal pattern wrong"); // R2

  property p_diag;
    @(posedge clk_i) disable iff (reset_i)
      (chk_auto && cfg_q[lds_pkg::CFG_PATTERN]) |=>
        switch_close_o == lds_pkg::PAT_DIAG;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic pattern wrong"); // R3

  property p_pattern;
    @(posedge clk_i) disable iff (reset_i)
      chk_auto |=>
        switch_close_o == ($past(cfg_q[lds_pkg::CFG_PATTERN]) ? lds_pkg::PAT_DIAG : lds_pkg::PAT_NORMAL);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern select wrong"); // R1

  property p_override;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o == $past(sw_q[lds_pkg::NSW-1:0]);
  endproperty
  a_override: assert property (p_override) else $error("override not applied"); // R11

  property p_manual_hold;
    @(posedge clk_i) disable iff (reset_i)
      ($past(chk_manual) && chk_manual && $stable(sw_q)) |=>
        $stable(switch_close_o);
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("override switches moved"); // R11

  property p_sw_pot;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o[lds_pkg::SW_BIAS_POT] == $past(sw_q[lds_pkg::SW_BIAS_POT]);
  endproperty
  a_sw_pot: assert property (p_sw_pot) else $error("switch four wrong"); // R12

  property p_sw_bias_filter;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o[lds_pkg::SW_BIAS_FILTER] == $past(sw_q[lds_pkg::SW_BIAS_FILTER]);
  endproperty
  a_sw_bias_filter: assert property (p_sw_bias_filter) else $error("switch three wrong"); // R13

  property p_sw_slow_tia;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o[lds_pkg::SW_SLOW_TIA] == $past(sw_q[lds_pkg::SW_SLOW_TIA]);
  endproperty
  a_sw_slow_tia: assert property (p_sw_slow_tia) else $error("switch two wrong"); // R14

  property p_sw_zero_filter;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o[lds_pkg::SW_ZERO_FILTER] == $past(sw_q[lds_pkg::SW_ZERO_FILTER]);
  endproperty
  a_sw_zero_filter: assert property (p_sw_zero_filter) else $error("switch one wrong"); // R15

  property p_sw_fast_tia;
    @(posedge clk_i) disable iff (reset_i)
      chk_manual |=>
        switch_close_o[lds_pkg::SW_FAST_TIA] == $past(sw_q[lds_pkg::SW_FAST_TIA]);
  endproperty
  a_sw_fast_tia: assert property (p_sw_fast_tia) else $error("switch zero wrong"); // R16

  property p_code_gate;
    @(posedge clk_i) disable iff (reset_i)
      !cfg_q[lds_pkg::CFG_WRITE_EN] |=>
        code_q == lds_pkg::CODE_RESET;
  endproperty
  a_code_gate: assert property (p_code_gate) else $error("code not cleared"); // R9

  property p_code_write;
    @(posedge clk_i) disable iff (reset_i)
      (wr_code && pready_o && cfg_q[lds_pkg::CFG_WRITE_EN]) |=>
        code_q == $past(pwdata_i[lds_pkg::CODE_W-1:0]);
  endproperty
  a_code_write: assert property (p_code_write) else $error("code write lost"); // R9

  property p_code_out;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        dac_code_o == $past(code_q);
  endproperty
  a_code_out: assert property (p_code_out) else $error("code output wrong"); // R9

  property p_cfg_write;
    @(posedge clk_i) disable iff (reset_i)
      (wr_config && pready_o) |=>
        cfg_q == $past(pwdata_i[lds_pkg::CFG_W-1:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // R18

  property p_sw_write;
    @(posedge clk_i) disable iff (reset_i)
      (wr_switch && pready_o) |=>
        sw_q == $past(pwdata_i[lds_pkg::SW_W-1:0]);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("switch write lost"); // R17

  property p_unmapped_keep;
    @(posedge clk_i) disable iff (reset_i)
      (psel_i && penable_i && pwrite_i && !hit) |=>
        $stable(cfg_q) && $stable(sw_q);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write landed"); // R18

  property p_cfg_read;
    @(posedge clk_i) disable iff (reset_i)
      (chk_read && paddr_i == lds_pkg::ADDR_CONFIG) |=>
        prdata_o == {25'h0, $past(cfg_q)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // R18

  property p_sw_read;
    @(posedge clk_i) disable iff (reset_i)
      (chk_read && paddr_i == lds_pkg::ADDR_SWITCH) |=>
        prdata_o == {26'h0, $past(sw_q)};
  endproperty
  a_sw_read: assert property (p_sw_read) else $error("switch read wrong"); // R17

  property p_code_read;
    @(posedge clk_i) disable iff (reset_i)
      (chk_read && paddr_i == lds_pkg::ADDR_CODE) |=>
        prdata_o == {14'h0, $past(code_q)};
  endproperty
  a_code_read: assert property (p_code_read) else $error("code read wrong"); // R9

  property p_unmapped;
    @(posedge clk_i) disable iff (reset_i)
      (setup_phase && !hit) |=>
        pslverr_o && (prdata_o == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused"); // R18

  property p_mapped_ok;
    @(posedge clk_i) disable iff (reset_i)
      (setup_phase && hit) |=>
        !pslverr_o;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused"); // R17

  property p_ready_answer;
    @(posedge clk_i) disable iff (reset_i)
      setup_phase |=>
        pready_o;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("ready missing in access");

  property p_ready_pulse;
    @(posedge clk_i) disable iff (reset_i)
      pready_o |=>
        !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_zero_mux;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        zero_node_source_select_o == $past(cfg_q[lds_pkg::CFG_ZERO_MUX]);
  endproperty
  a_zero_mux: assert property (p_zero_mux) else $error("zero node select wrong"); // R4

  property p_bias_mux;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        bias_node_source_select_o == $past(cfg_q[lds_pkg::CFG_BIAS_MUX]);
  endproperty
  a_bias_mux: assert property (p_bias_mux) else $error("bias node select wrong"); // R5

  property p_ref;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        reference_source_select_o == $past(cfg_q[lds_pkg::CFG_REF_SEL]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong"); // R7

  property p_code_src;
    @(posedge clk_i) disable iff (reset_i)
      1'b1 |=>
        code_source_select_o == $past(cfg_q[lds_pkg::CFG_CODE_SRC]);
  endproperty
  a_code_src: assert property (p_code_src) else $error("code source select wrong"); // R10
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [15:0] pa = 16'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy, err, zs, bs, rs, pd, cs;
  logic [4:0] sw;
  logic [17:0] code;
  logic [64:0] q[$];
  logic [64:0] e;
  logic [31:0] r = 32'h2e;
  logic [31:0] v;
  int mismatches = 0;
  int n_compared = 0;

  lds_top lds_top_inst (.clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .switch_close_o(sw), .zero_node_source_select_o(zs),
    .bias_node_source_select_o(bs), .reference_source_select_o(rs),
    .converter_power_down_o(pd), .code_source_select_o(cs), .dac_code_o(code));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic [31:0] m, input logic er);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    q.push_back({er, m, ex});
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 32'h0, 32'h0, 1'h0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ex);
    apb(1'h0, a, 32'h0, ex, 32'hffffffff, 1'h0);
  endtask

  // Switch and select outputs follow one edge after the write lands
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  always @(negedge clk) begin
    if (psel && pen && rdy === 1'b1) begin
      e = q.pop_front();
      chk("prdata", e[31:0], prd & e[63:32]);
      chk("pslverr", {31'h0, e[64]}, {31'h0, err});
    end
  end

  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    settle();
    chk("sw", 32'h0, 32'(sw));
    chk("pd", 32'h1, 32'(pd));
    chk("sel", 32'h0, 32'({zs, bs, rs, cs}));
    chk("code", 32'h0, 32'(code));
    rd(16'h2128, 32'h2);
    rd(16'h2124, 32'hc);
    rd(16'h2120, 32'h0);
    apb(1'h0, 16'h2130, 32'h0, 32'h0, 32'hffffffff, 1'h1);
    wr(16'h2128, 32'h22);
    settle();
    chk("sw", 32'h0, 32'(sw));
    for (int i = 0; i < 2; i++) begin
      wr(16'h2128, {26'h0, i[0], 5'h0});
      settle();
      chk("sw", i ? 32'h11 : 32'h0c, 32'(sw));
    end
    // Both mux bits kept equal, power stays on
    for (int i = 0; i < 8; i++) begin
      r = xs(r);
      v = r & ~32'h12 | {r[3], 4'h0};
      wr(16'h2128, v);
      settle();
      chk("sel", {28'h0, v[4:2], v[6]}, {28'h0, zs, bs, rs, cs});
      chk("sw", v[5] ? 32'h11 : 32'h0c, 32'(sw));
      chk("pd", 32'h0, 32'(pd));
      rd(16'h2128, v & 32'h7f);
    end
    for (int i = 0; i < 8; i++) begin
      r = xs(r);
      v = r | 32'h20;
      wr(16'h2124, v);
      settle();
      chk("sw", 32'(v[4:0]), 32'(sw));
      rd(16'h2124, v & 32'h3f);
    end
    wr(16'h2128, 32'h2);
    settle();
    chk("sw", 32'h0, 32'(sw));
    chk("pd", 32'h1, 32'(pd));
    wr(16'h2128, 32'h0);
    wr(16'h2120, r);
    settle();
    chk("code", 32'h0, 32'(code));
    wr(16'h2128, 32'h1);
    r = xs(r);
    wr(16'h2120, r);
    settle();
    chk("code", 32'(r[17:0]), 32'(code));
    rd(16'h2120, r & 32'h3ffff);
    wr(16'h2128, 32'h0);
    // Clearing takes one edge in the register and one more at the pin
    settle();
    settle();
    chk("code", 32'h0, 32'(code));
    close_out();
  end
endmodule
